// ===== verilog/acf_top.sv
// Second converter configuration register with channel bank, clock force and
// high-speed sequence controls; assumes a plain strobe register port on sys_clk.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module acf_top
	import acf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [1:0] input_clock_select,
	input wire logic alternate_clock,
	input wire logic conv_start,
	input wire logic conv_continuous,
	input wire logic conv_stop,
	output logic [31:0] reg_rdata,
	output logic channel_bank_select,
	output logic async_clock_out_en,
	output logic conversion_clock,
	output logic conv_busy,
	output logic conv_done,
	output logic [4:0] conv_cycles
);
	import acf_pkg::*;
	acf_cfg_if cfg_bus();
	logic [31:0] config_reg_two_reg;
	logic [2:0] alt_sync_reg;
	logic alt_level_reg;
	logic half_reg;
	logic async_div_reg;
	logic async_run;
	logic busy;
	logic done;
	logic [4:0] len;
	logic clk_sel_next;
	assign cfg_bus.bank_select = config_reg_two_reg[BIT_BANK];
	assign cfg_bus.force_enable = config_reg_two_reg[BIT_FORCE];
	assign cfg_bus.high_speed = config_reg_two_reg[BIT_HS];
	assign cfg_bus.clock_select = input_clock_select;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_reg_two_reg <= CONFIG_REG_TWO_RESET;
		end else if (reg_write && reg_addr == ADDR_CONFIG_TWO) begin
			config_reg_two_reg <= reg_wdata & CONFIG_REG_TWO_WMASK;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read && reg_addr == ADDR_CONFIG_TWO) begin
			reg_rdata <= config_reg_two_reg & CONFIG_REG_TWO_WMASK;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
	// Alternate clock pin synchroniser
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alt_sync_reg <= 3'h0;
			alt_level_reg <= 1'b0;
		end else begin
			alt_sync_reg <= {alt_sync_reg[1:0], alternate_clock};
			if (alt_sync_reg[1] == alt_sync_reg[2]) begin
				alt_level_reg <= alt_sync_reg[2];
			end
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_reg <= 1'b0;
			async_div_reg <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
			async_div_reg <= async_run ? ~async_div_reg : 1'b0;
		end
	end
	always_comb begin
		unique case (input_clock_select)
			SEL_BUS: clk_sel_next = 1'b1;
			SEL_BUS_HALF: clk_sel_next = half_reg;
			SEL_ALT: clk_sel_next = alt_level_reg;
			SEL_ASYNC: clk_sel_next = async_div_reg;
		endcase
	end
	acf_seq acf_seq_i (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.cfg(cfg_bus),
		.start(conv_start),
		.continuous(conv_continuous),
		.stop(conv_stop),
		.async_run(async_run),
		.busy(busy),
		.done(done),
		.conv_len(len)
	);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			channel_bank_select <= 1'b0;
			async_clock_out_en <= 1'b0;
			conversion_clock <= 1'b0;
			conv_busy <= 1'b0;
			conv_done <= 1'b0;
			conv_cycles <= 5'h00;
		end else begin
			channel_bank_select <= config_reg_two_reg[BIT_BANK];
			async_clock_out_en <= async_run;
			conversion_clock <= clk_sel_next;
			conv_busy <= busy;
			conv_done <= done;
			conv_cycles <= len;
		end
	end
	a_reserved_read_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_read |=> reg_rdata[31:5] == 27'h0 && reg_rdata[1:0] == 2'h0)
		else $error("reserved bits nonzero");
	a_bank_follows_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(reg_write && reg_addr == ADDR_CONFIG_TWO) |=> ##1
		channel_bank_select == $past(reg_wdata[BIT_BANK], 2)) else $error("bank wrong");
	a_bank_output_seen: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(reg_write && reg_addr == ADDR_CONFIG_TWO) |=> ##2
		channel_bank_select == $past(reg_wdata[BIT_BANK], 3)) else $error("bank late");
	a_bus_clock_pick: assert property (@(posedge sys_clk) disable iff (!reset_n)
		input_clock_select == SEL_BUS |=> conversion_clock) else $error("bus clock lost");
	a_reset_fields_zero: assert property (@(posedge sys_clk)
		!reset_n |=> config_reg_two_reg == CONFIG_REG_TWO_RESET) else $error("reset not clear");
endmodule

// ===== inc/acf_pkg.sv
// Constants and types for the second converter configuration register.
// Assumes one 50 MHz clock, with software access over a plain strobe port.
package acf_pkg;
	localparam logic [7:0] ADDR_CONFIG_TWO = 8'h0c;
	localparam int BIT_BANK = 4;
	localparam int BIT_FORCE = 3;
	localparam int BIT_HS = 2;
	localparam logic [31:0] CONFIG_REG_TWO_WMASK = 32'h0000001c;
	localparam logic [31:0] CONFIG_REG_TWO_RESET = 32'h00000000;
	localparam logic [1:0] SEL_BUS = 2'h0;
	localparam logic [1:0] SEL_BUS_HALF = 2'h1;
	localparam logic [1:0] SEL_ALT = 2'h2;
	localparam logic [1:0] SEL_ASYNC = 2'h3;
	localparam int CLK_PERIOD_NS = 20;
	localparam int STARTUP_NS = 100;
	localparam logic [3:0] STARTUP_CYC = 4'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] NORMAL_CYC = 5'h14;
	localparam logic [4:0] HS_EXTRA_CYC = 5'h02;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WARM = 2'b01,
		ST_CONV = 2'b11
	} acf_state_type;
endpackage

// ===== inc/acf_cfg_if.sv
// Carries configuration fields from the register file, and the clock-select input pins, to the sequencer.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
interface acf_cfg_if;
	logic bank_select;
	logic force_enable;
	logic high_speed;
	logic [1:0] clock_select;
	modport src (output bank_select, force_enable, high_speed, clock_select);
	modport dst (input bank_select, force_enable, high_speed, clock_select);
endinterface

// ===== verilog/acf_seq.sv
// Conversion sequencer and asynchronous clock gating.
// Assumes start is a one-cycle pulse on sys_clk.
`timescale 1ns/100ps
module acf_seq
	import acf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	acf_cfg_if.dst cfg,
	input wire logic start,
	input wire logic continuous,
	input wire logic stop,
	output logic async_run,
	output logic busy,
	output logic done,
	output logic [4:0] conv_len
);
	acf_state_type state_reg;
	logic [3:0] warm_reg;
	logic [4:0] cnt_reg;
	logic async_sel;
	logic async_on;
	assign async_sel = (cfg.clock_select == SEL_ASYNC);
	assign async_on = cfg.force_enable || (async_sel && state_reg != ST_IDLE);
	assign async_run = async_on;
	assign busy = (state_reg != ST_IDLE);
	assign conv_len = cfg.high_speed ? NORMAL_CYC + HS_EXTRA_CYC : NORMAL_CYC;
	// Warm timer counts only while the clock is already running
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			warm_reg <= 4'h0;
		end else if (!async_on) begin
			warm_reg <= 4'h0;
		end else if (warm_reg != STARTUP_CYC) begin
			warm_reg <= warm_reg + 4'h1;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						// Forced clock skips start-up latency
						if (async_sel && !cfg.force_enable) begin
							state_reg <= ST_WARM;
						end else begin
							state_reg <= ST_CONV;
						end
						cnt_reg <= 5'h00;
					end
				end
				ST_WARM: begin
					if (stop) begin
						state_reg <= ST_IDLE;
					end else if (warm_reg == STARTUP_CYC) begin
						state_reg <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (stop) begin
						state_reg <= ST_IDLE;
					end else if (cnt_reg == conv_len - 5'h01) begin
						done <= 1'b1;
						cnt_reg <= 5'h00;
						if (!continuous) begin
							state_reg <= ST_IDLE;
						end
					end else begin
						cnt_reg <= cnt_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
	a_force_clock_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cfg.force_enable |-> async_run) else $error("forced clock stopped");
	a_idle_clock_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!cfg.force_enable && !busy) |-> !async_run) else $error("idle clock ran");
	a_forced_no_warm: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(start && !busy && cfg.force_enable) |=> state_reg == ST_CONV)
		else $error("forced start warmed up");
	a_cold_warm_up: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(start && !busy && !cfg.force_enable && async_sel) |=> state_reg == ST_WARM)
		else $error("cold start skipped warm up");
	a_length_hs: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cfg.high_speed |-> conv_len == 5'd22) else $error("high speed length wrong");
	a_length_norm: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!cfg.high_speed |-> conv_len == 5'd20) else $error("normal length wrong");
endmodule

// ===== dv/acf_top_tb.sv
// Self-checking bench for the second converter configuration register.
// Assumes acf_top with a plain strobe register port on a 50 MHz sys_clk.
`timescale 1ns/100ps
module acf_top_tb;
	import acf_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [1:0] input_clock_select = 2'h0;
	logic alternate_clock;
	logic [2:0] alt_div = 3'h0;
	logic conv_start = 1'b0;
	logic [31:0] reg_rdata;
	logic channel_bank_select;
	logic async_clock_out_en;
	logic conversion_clock;
	logic conv_busy;
	logic conv_done;
	logic [4:0] conv_cycles;
	int n_fail = 0;
	int num_checks = 0;
	int ln, lh, lf, lu, t;
	logic seen;

	acf_top acf_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.input_clock_select(input_clock_select), .alternate_clock(alternate_clock),
		.conv_start(conv_start), .conv_continuous(1'b0), .conv_stop(1'b0),
		.reg_rdata(reg_rdata), .channel_bank_select(channel_bank_select),
		.async_clock_out_en(async_clock_out_en), .conversion_clock(conversion_clock),
		.conv_busy(conv_busy), .conv_done(conv_done), .conv_cycles(conv_cycles));

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) alt_div <= alt_div + 3'h1;
	assign alternate_clock = alt_div[2];

	task automatic close_out();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
			n_fail++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp, "read data");
	endtask

	// Start one conversion, count cycles to done, note async clock activity
	task automatic conv(output int n, output logic s);
		@(posedge sys_clk);
		conv_start <= 1'b1;
		@(posedge sys_clk);
		conv_start <= 1'b0;
		n = 1;
		s = 1'b0;
		while (conv_done !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (async_clock_out_en === 1'b1) s = 1'b1;
		end
		if (n >= 300) begin
			chk(32'h0, 32'h1, "conversion never finished");
			close_out();
		end
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task automatic toggles(input logic [1:0] s, output int k);
		logic prev;
		@(posedge sys_clk);
		input_clock_select <= s;
		repeat (8) @(posedge sys_clk);
		#1;
		prev = conversion_clock;
		k = 0;
		repeat (16) begin
			@(posedge sys_clk);
			#1;
			if (conversion_clock !== prev) k++;
			prev = conversion_clock;
		end
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ADDR_CONFIG_TWO, CONFIG_REG_TWO_RESET);
		chk(32'(channel_bank_select), 32'h0, "bank after reset");
		chk(32'(async_clock_out_en), 32'h0, "async idle after reset");
		wr(ADDR_CONFIG_TWO, 32'hffffffff);
		rd(ADDR_CONFIG_TWO, 32'h0000001c);
		chk(32'(channel_bank_select), 32'h1, "alternate bank");
		wr(8'h10, 32'h0);
		rd(8'h10, 32'h0);
		rd(ADDR_CONFIG_TWO, 32'h0000001c);
		wr(ADDR_CONFIG_TWO, 32'hffffffe3);
		rd(ADDR_CONFIG_TWO, 32'h0);
		chk(32'(channel_bank_select), 32'h0, "primary bank");
		conv(ln, seen);
		chk(32'(seen), 32'h0, "async ran while bus clock chosen");
		chk(32'(conv_cycles), 32'(NORMAL_CYC), "normal length");
		wr(ADDR_CONFIG_TWO, 32'h04);
		conv(lh, seen);
		chk(32'(conv_cycles), 32'(NORMAL_CYC + HS_EXTRA_CYC), "high speed length");
		chk(32'(lh), 32'(ln + 2), "high speed duration");
		wr(ADDR_CONFIG_TWO, 32'h08);
		chk(32'(async_clock_out_en), 32'h1, "forced clock while idle");
		toggles(SEL_BUS, t);
		chk(32'(t), 32'h0, "bus clock level steady");
		chk(32'(conversion_clock), 32'h1, "bus clock level");
		toggles(SEL_BUS_HALF, t);
		chk(32'(t > 0), 32'h1, "halved bus clock runs");
		toggles(SEL_ALT, t);
		chk(32'(t > 0), 32'h1, "alternate clock runs");
		toggles(SEL_ASYNC, t);
		chk(32'(t > 0), 32'h1, "async clock runs");
		conv(lf, seen);
		wr(ADDR_CONFIG_TWO, 32'h0);
		chk(32'(async_clock_out_en), 32'h0, "unforced async idle");
		conv(lu, seen);
		chk(32'(seen), 32'h1, "async ran during conversion");
		chk(32'(lu > lf), 32'h1, "start-up delay only unforced");
		chk(32'(async_clock_out_en), 32'h0, "async stopped after end");
		close_out();
	end
endmodule
